// file: rtl/pcs_cfg.svh
// Constants for the clock synthesizer control block
//==========================================================================
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

//==========================================================================
// Register map
`define PCS_CTRL_OFS 8'h00
`define PCS_CTRL_RESET 16'h3f00
`define PCS_WRITE_MASK 16'hff00
`define PCS_W_BIT 15
`define PCS_X_BIT 14
`define PCS_Y_MSB 13
`define PCS_Y_LSB 8
`define PCS_LOCK_BIT 3
`define PCS_FAST_W_MSB 13
`define PCS_FAST_W_LSB 12
`define PCS_FAST_Y_MSB 10
`define PCS_FAST_Y_LSB 8

//==========================================================================
// Timing
`define PCS_CLK_PERIOD_NS 8
`define PCS_LOCK_TIME_NS 20000
`define PCS_LOCK_CYCLES ((`PCS_LOCK_TIME_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS)
`define PCS_SETTLE_CYCLES 4
`define PCS_DIV4_LAST 2'h3
`define PCS_DIV2_LAST 2'h1

`endif

// file: rtl/pcs_lock_timer.sv
// Lock acquisition timer, restarted on every relock request
module pcs_lock_timer #(
    parameter int LOCK_CYCLES = 2500
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control
    input wire logic i_start,
    output logic o_done
);

    localparam int CW = $clog2(LOCK_CYCLES + 1);

    initial begin
        if (LOCK_CYCLES < 1) begin
            $error("pcs_lock_timer: LOCK_CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    wire at_end = (count == CW'(LOCK_CYCLES));

    // Restart wins over counting so a change mid-acquisition lengthens the wait
    assign next_count = i_start ? '0 : (at_end ? count : count + CW'(1));

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= '0;
            o_done <= 1'b0;
        end else begin
            count <= next_count;
            o_done <= !i_start && (next_count == CW'(LOCK_CYCLES));
        end
    end

endmodule

// file: rtl/pcs_pkg.sv
// Types shared by the clock synthesizer control block
package pcs_pkg;

    //======================================================================
    // Control register fields
    typedef struct packed {
        logic prescale_w;
        logic div_sel_x;
        logic [5:0] modulus_y;
    } pcs_ctrl_t;

    //======================================================================
    // Divider settings driven to the analog side
    typedef struct packed {
        logic [2:0] feedback_prescale;
        logic [5:0] feedback_modulus;
        logic [2:0] post_modulus;
        logic output_divide_sel;
    } pcs_divs_t;

    //======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        PCS_ST_SAMPLE,
        PCS_ST_BYPASS,
        PCS_ST_ACQUIRE,
        PCS_ST_LOCKED
    } pcs_state_t;

endpackage

// file: rtl/pcs_sync.sv
// Three-stage input synchroniser, accepting a change when stages two and three agree
module pcs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    initial begin
        if (WIDTH < 1) begin
            $error("pcs_sync: WIDTH must be at least 1");
        end
    end

    //======================================================================
    // Per-bit stages
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            logic agreed;
            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                    agreed <= 1'b0;
                end else begin
                    stage1 <= i_async[g];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        agreed <= stage3;
                    end
                end
            end
            assign o_sync[g] = agreed;
        end
    endgenerate

endmodule

// file: rtl/pcs_synth_ctrl.sv
// Clock synthesizer control: register, strap, lock sequencing and output divider
//
// Added by the designer: the plain strobed port and the address map.
`include "pcs_cfg.svh"
module pcs_synth_ctrl
    import pcs_pkg::*;
#(
    parameter bit FAST_REF = 1'b0,
    parameter int ADDR_WIDTH = 8,
    parameter int LOCK_CYCLES = `PCS_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    output logic [15:0] o_rd_data,
    // Pins and analog side
    input wire logic i_clock_mode_strap,
    input wire logic i_external_clock_input,
    input wire logic i_vco_locked,
    input wire logic i_reference_select,
    // Synthesizer control
    output logic o_pll_enable,
    output pcs_divs_t o_divs,
    output logic o_synth_lock_flag,
    output logic o_sys_clock_en,
    output logic o_chip_resetn
);

    initial begin
        if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin
            $error("pcs_synth_ctrl: ADDR_WIDTH out of range");
        end
        if (LOCK_CYCLES < 1) begin
            $error("pcs_synth_ctrl: LOCK_CYCLES must be at least 1");
        end
    end

    //======================================================================
    // Pin synchronisers
    logic [3:0] pins_sync;
    wire strap_sync = pins_sync[0];
    wire ext_clk_sync = pins_sync[1];
    wire vco_locked_sync = pins_sync[2];
    wire ref_sel_sync = pins_sync[3];

    pcs_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_async({i_reference_select, i_vco_locked, i_external_clock_input,
                  i_clock_mode_strap}),
        .o_sync(pins_sync)
    );

    //======================================================================
    // Registers
    pcs_state_t state;
    pcs_state_t next_state;
    logic [15:0] ctrl_word;
    logic [2:0] settle_count;
    logic ref_sel_seen;
    logic ext_clk_prev;
    logic [1:0] div_count;
    logic released;

    //======================================================================
    // Register decode
    wire ctrl_hit = (i_addr == ADDR_WIDTH'(`PCS_CTRL_OFS));
    wire ctrl_write = i_wr_strobe && ctrl_hit;
    wire ctrl_read = i_rd_strobe && ctrl_hit;
    wire [15:0] write_value = (i_wr_data & `PCS_WRITE_MASK)
                            | (ctrl_word & ~`PCS_WRITE_MASK);

    // Lock bit never stored; written value is ignored there
    wire [15:0] read_value = (ctrl_word & `PCS_WRITE_MASK)
                           | (16'(o_synth_lock_flag) << `PCS_LOCK_BIT);
    wire [15:0] next_rd_data = ctrl_read ? read_value : 16'h0000;

    //======================================================================
    // Field views
    pcs_ctrl_t cur_f;
    pcs_ctrl_t new_f;
    assign cur_f = pcs_ctrl_t'(ctrl_word[15:8]);
    assign new_f = pcs_ctrl_t'(write_value[15:8]);

    // Feedback-path bits differ per variant; only they disturb the loop
    wire [6:0] cur_fb = FAST_REF
        ? {4'h0, ctrl_word[`PCS_W_BIT], ctrl_word[`PCS_FAST_W_MSB:`PCS_FAST_W_LSB]}
        : {cur_f.prescale_w, cur_f.modulus_y};
    wire [6:0] new_fb = FAST_REF
        ? {4'h0, write_value[`PCS_W_BIT], write_value[`PCS_FAST_W_MSB:`PCS_FAST_W_LSB]}
        : {new_f.prescale_w, new_f.modulus_y};
    wire fb_changed = ctrl_write && (new_fb != cur_fb);

    // Reference switch changes the other comparator input
    wire ref_changed = (ref_sel_sync != ref_sel_seen);

    wire pll_mode = (state == PCS_ST_ACQUIRE) || (state == PCS_ST_LOCKED);
    wire relock = pll_mode && (fb_changed || ref_changed);

    //======================================================================
    // Lock timer
    logic timer_done;
    // A lost lock must wait the full acquisition again, like any relock
    wire lock_lost = (state == PCS_ST_LOCKED) && !vco_locked_sync;
    wire timer_start = relock || lock_lost || (state == PCS_ST_SAMPLE);

    pcs_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_timer (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_start(timer_start),
        .o_done(timer_done)
    );

    //======================================================================
    // Sequencer
    wire settled = (settle_count == 3'(`PCS_SETTLE_CYCLES));
    wire acquired = timer_done && vco_locked_sync && !relock;

    always_comb begin
        next_state = state;
        case (state)
            PCS_ST_SAMPLE: begin
                if (settled) begin
                    // Strap caught once after reset release
                    next_state = strap_sync ? PCS_ST_ACQUIRE : PCS_ST_BYPASS;
                end
            end
            PCS_ST_BYPASS: begin
                next_state = PCS_ST_BYPASS;
            end
            PCS_ST_ACQUIRE: begin
                if (acquired) begin
                    next_state = PCS_ST_LOCKED;
                end
            end
            PCS_ST_LOCKED: begin
                if (relock || !vco_locked_sync) begin
                    next_state = PCS_ST_ACQUIRE;
                end
            end
            default: begin
                next_state = PCS_ST_SAMPLE;
            end
        endcase
    end

    wire next_lock_flag = (next_state == PCS_ST_LOCKED);
    // Chip reset released on first lock, or at once in bypass; later relocks keep it
    wire next_released = released || next_lock_flag || (next_state == PCS_ST_BYPASS);

    //======================================================================
    // Output divider model
    wire next_x = ctrl_write ? new_f.div_sel_x : cur_f.div_sel_x;
    wire [1:0] div_last = next_x ? `PCS_DIV2_LAST : `PCS_DIV4_LAST;
    // Terminal count is compared, not loaded, so a divide change acts at once
    wire div_wrap = (div_count >= div_last);
    wire [1:0] next_div_count = div_wrap ? 2'h0 : div_count + 2'h1;
    wire ext_edge = ext_clk_sync && !ext_clk_prev;
    wire next_sys_en = (next_state == PCS_ST_BYPASS) ? ext_edge
                     : (pll_mode && div_wrap);

    //======================================================================
    // Divider fields to the analog side
    pcs_divs_t next_divs;
    wire [15:0] next_word = ctrl_write ? write_value : ctrl_word;
    // Analog side sees the reset register's dividers during reset, not zeros
    localparam logic [15:0] CTRL_RST = `PCS_CTRL_RESET;
    localparam pcs_divs_t DIVS_RST = FAST_REF
        ? pcs_divs_t'({CTRL_RST[`PCS_W_BIT], CTRL_RST[`PCS_FAST_W_MSB:`PCS_FAST_W_LSB], 6'h00,
                       CTRL_RST[`PCS_FAST_Y_MSB:`PCS_FAST_Y_LSB], CTRL_RST[`PCS_X_BIT]})
        : pcs_divs_t'({2'h0, CTRL_RST[`PCS_W_BIT], CTRL_RST[`PCS_Y_MSB:`PCS_Y_LSB], 3'h0,
                       CTRL_RST[`PCS_X_BIT]});
    always_comb begin
        next_divs = '0;
        next_divs.output_divide_sel = next_word[`PCS_X_BIT];
        if (FAST_REF) begin
            // f = fref/128 * 4(Y+1) * 2^(2W+X)
            next_divs.feedback_prescale = {next_word[`PCS_W_BIT],
                                           next_word[`PCS_FAST_W_MSB:`PCS_FAST_W_LSB]};
            next_divs.post_modulus = next_word[`PCS_FAST_Y_MSB:`PCS_FAST_Y_LSB];
        end else begin
            // f = 4 fref (Y+1) 2^(2W+X)
            next_divs.feedback_prescale = {2'h0, next_word[`PCS_W_BIT]};
            next_divs.feedback_modulus = next_word[`PCS_Y_MSB:`PCS_Y_LSB];
        end
    end

    //======================================================================
    // State and register flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= PCS_ST_SAMPLE;
            ctrl_word <= `PCS_CTRL_RESET;
            settle_count <= 3'h0;
            ref_sel_seen <= 1'b0;
            ext_clk_prev <= 1'b0;
            div_count <= 2'h0;
            released <= 1'b0;
        end else begin
            state <= next_state;
            if (ctrl_write) begin
                ctrl_word <= write_value;
            end
            if (!settled) begin
                settle_count <= settle_count + 3'h1;
            end
            ref_sel_seen <= ref_sel_sync;
            ext_clk_prev <= ext_clk_sync;
            div_count <= next_div_count;
            released <= next_released;
        end
    end

    //======================================================================
    // Output flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= 16'h0000;
            o_pll_enable <= 1'b0;
            o_divs <= DIVS_RST;
            o_synth_lock_flag <= 1'b0;
            o_sys_clock_en <= 1'b0;
            o_chip_resetn <= 1'b0;
        end else begin
            o_rd_data <= next_rd_data;
            o_pll_enable <= (next_state != PCS_ST_BYPASS) && (next_state != PCS_ST_SAMPLE);
            o_divs <= next_divs;
            o_synth_lock_flag <= next_lock_flag;
            o_sys_clock_en <= next_sys_en;
            o_chip_resetn <= next_released;
        end
    end

endmodule

// file: test/pcs_synth_ctrl_sva.sv
// Assertion checker for the clock synthesizer control block
module pcs_synth_ctrl_sva
    import pcs_pkg::*;
#(
    parameter bit FAST_REF = 1'b0,
    parameter int LOCK_CYCLES = 2500
) (
    // Clock, reset, register port
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    input wire logic [15:0] o_rd_data,
    // Synthesizer outputs
    input wire pcs_divs_t o_divs,
    input wire logic o_pll_enable,
    input wire logic o_synth_lock_flag,
    input wire logic o_sys_clock_en,
    input wire logic o_chip_resetn
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    //==========================================================
    // Helpers
    wire wr = i_wr_strobe && i_addr == 8'h00;
    wire x = o_divs.output_divide_sel;
    wire fb_same = FAST_REF
        ? {i_wr_data[15], i_wr_data[13:12]} == o_divs.feedback_prescale
        : i_wr_data[15] == o_divs.feedback_prescale[0]
          && i_wr_data[13:8] == o_divs.feedback_modulus;
    pcs_divs_t want;
    assign want = FAST_REF
        ? pcs_divs_t'({i_wr_data[15], i_wr_data[13:12], 6'h00, i_wr_data[10:8], i_wr_data[14]})
        : pcs_divs_t'({2'h0, i_wr_data[15], i_wr_data[13:8], 3'h0, i_wr_data[14]});
    // Fast bit 11 is stored but drives nothing, so it cannot be predicted
    localparam logic [15:0] RD_MASK = FAST_REF ? 16'hf7ff : 16'hffff;
    wire run4 = o_pll_enable && o_synth_lock_flag && !x;
    wire run2 = o_pll_enable && o_synth_lock_flag && x;
    wire [15:0] img = FAST_REF
        ? {o_divs.feedback_prescale[2], x, o_divs.feedback_prescale[1:0], 1'b0,
           o_divs.post_modulus, 4'h0, o_synth_lock_flag, 3'h0}
        : {o_divs.feedback_prescale[0], x, o_divs.feedback_modulus,
           4'h0, o_synth_lock_flag, 3'h0};
    logic [15:0] low_cnt;
    logic r4;
    logic r2;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            low_cnt <= 16'h0000;
            r4 <= 1'b0;
            r2 <= 1'b0;
        end else begin
            low_cnt <= o_synth_lock_flag ? 16'h0000 : low_cnt + 16'h0001;
            r4 <= run4;
            r2 <= run2;
        end
    end
    // Previous cycle already steady, so a ratio switch never starts a check
    sequence s_quarter;
        o_sys_clock_en && run4 && r4;
    endsequence
    sequence s_half;
        o_sys_clock_en && run2 && r2;
    endsequence
    //==========================================================
    // Properties
    rd_idle_a: assert property (!$past(i_rd_strobe) |-> o_rd_data == 16'h0000)
        else $error("read data outside slot");
    rd_image_a: assert property ($past(i_rd_strobe) && $past(i_addr) == 8'h00
        |-> (o_rd_data & RD_MASK) == $past(img)) else $error("read image wrong");
    wr_divs_a: assert property (wr |=> o_divs == $past(want))
        else $error("dividers not loaded");
    x_only_a: assert property (o_synth_lock_flag && wr && fb_same |=> o_synth_lock_flag)
        else $error("relock on divide select");
    relock_a: assert property (o_synth_lock_flag && wr && !fb_same |=> !o_synth_lock_flag)
        else $error("no relock on feedback change");
    lock_time_a: assert property ($rose(o_synth_lock_flag) |-> low_cnt >= LOCK_CYCLES)
        else $error("lock too early");
    chip_hold_a: assert property ($rose(o_chip_resetn) |-> o_synth_lock_flag || !o_pll_enable)
        else $error("chip reset freed before lock");
    chip_keep_a: assert property (o_chip_resetn |=> o_chip_resetn)
        else $error("chip reset came back");
    bypass_a: assert property (o_chip_resetn && !o_pll_enable |-> !o_synth_lock_flag)
        else $error("lock flag in bypass");
    quarter_a: assert property (s_quarter |=> (!o_sys_clock_en || !run4)[*3]
        ##1 (o_sys_clock_en || !run4)) else $error("divide by four spacing");
    half_a: assert property (s_half |=> (!o_sys_clock_en || !run2)
        ##1 (o_sys_clock_en || !run2)) else $error("divide by two spacing");
endmodule

// file: test/tb.sv
// Self-checking testbench for the clock synthesizer control block
module tb
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LOCK_CYCLES = 12;
    // Half the top multiplier with the slow reference
    localparam int HALF_MAX_MULT = 256;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_wr_strobe = 1'b0;
    logic i_rd_strobe = 1'b0;
    logic strap = 1'b1;
    logic ext_clk = 1'b0;
    logic vco_ok = 1'b1;
    logic ref_sel = 1'b0;
    logic [15:0] o_rd_data;
    pcs_divs_t o_divs;
    pcs_divs_t f_divs;
    logic o_pll_enable, o_synth_lock_flag, o_sys_clock_en, o_chip_resetn;
    logic [15:0] cur = 16'h3f00;
    logic [15:0] d;
    integer seed = 32'h9649d0c9;
    int err_count = 0;
    int n_compared = 0;
    int cnt;
    always #4 i_clock = ~i_clock;
    // Levels of about 20 ns give the agreement filter two or three samples; edges miss i_clock
    always begin
        #20.5 ext_clk = ~ext_clk;
        #19.5 ext_clk = ~ext_clk;
    end

    pcs_synth_ctrl #(.LOCK_CYCLES(LOCK_CYCLES)) dut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
        .o_rd_data(o_rd_data), .i_clock_mode_strap(strap),
        .i_external_clock_input(ext_clk), .i_vco_locked(vco_ok),
        .i_reference_select(ref_sel), .o_pll_enable(o_pll_enable), .o_divs(o_divs),
        .o_synth_lock_flag(o_synth_lock_flag), .o_sys_clock_en(o_sys_clock_en),
        .o_chip_resetn(o_chip_resetn));

    // Fast-reference variant shares the stimulus; only its field mapping is compared
    pcs_synth_ctrl #(.FAST_REF(1'b1), .LOCK_CYCLES(LOCK_CYCLES)) dut_fast (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
        .o_rd_data(), .i_clock_mode_strap(strap),
        .i_external_clock_input(ext_clk), .i_vco_locked(vco_ok),
        .i_reference_select(ref_sel), .o_pll_enable(), .o_divs(f_divs),
        .o_synth_lock_flag(), .o_sys_clock_en(), .o_chip_resetn());

    //==========================================================
    // Expectations and bus tasks
    // VCO must stay within twice the top system clock: set X above half of it
    function automatic logic [15:0] keep_vco(input logic [15:0] v);
        int m;
        m = 4 * (int'(v[13:8]) + 1) * (v[15] ? 4 : 1);
        if (m > HALF_MAX_MULT) v[14] = 1'b1;
        return v;
    endfunction
    function automatic logic [15:0] image(input logic [15:0] v, input logic lk);
        return {v[15:8], 4'h0, lk, 3'h0};
    endfunction
    function automatic logic fb_changed(input logic [15:0] a, input logic [15:0] b);
        return a[15] != b[15] || a[13:8] != b[13:8];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wr_data <= v;
        i_wr_strobe <= 1'b1;
        @(posedge i_clock);
        i_wr_strobe <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd_strobe <= 1'b1;
        @(posedge i_clock);
        i_rd_strobe <= 1'b0;
        #1;
        chk(o_rd_data, exp);
    endtask
    task automatic wait_lock();
        for (int k = 0; k < 200 && o_synth_lock_flag !== 1'b1; k++) begin
            @(posedge i_clock);
            #1;
        end
        chk(o_synth_lock_flag, 1'b1);
    endtask
    task automatic pulses(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge i_clock);
            #1;
            cnt += int'(o_sys_clock_en === 1'b1);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    //==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clock);
        i_resetn <= 1'b1;
        #1;
        chk(o_chip_resetn, 1'b0);
        wait_lock();
        chk({o_pll_enable, o_chip_resetn}, 2'b11);
        rd(8'h00, image(16'h3f00, 1'b1));
        rd(8'h10, 16'h0000);
        wr(8'h10, 16'h0000);
        wr(8'h00, 16'h3ff7);
        rd(8'h00, image(16'h3f00, 1'b1));
        pulses(16);
        chk(cnt[15:0], 16'h0004);
        wr(8'h00, 16'h7f00);
        chk(o_synth_lock_flag, 1'b1);
        pulses(16);
        chk(cnt[15:0], 16'h0008);
        cur = 16'h7f00;
        // Corners first: largest multiplier, then smallest
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 16'hff00 : (i == 1) ? 16'h0000 : 16'($random(seed));
            d = keep_vco(d);
            wr(8'h00, d);
            if (fb_changed(cur, d)) chk(o_synth_lock_flag, 1'b0);
            chk({o_divs.feedback_prescale, o_divs.feedback_modulus, x_bit()},
                {2'b00, d[15], d[13:8], d[14]});
            chk({f_divs.feedback_prescale, f_divs.post_modulus, f_divs.feedback_modulus},
                {d[15], d[13:12], d[10:8], 6'h00});
            cur = d & 16'hff00;
            wait_lock();
            rd(8'h00, image(cur, 1'b1));
        end
        @(posedge i_clock);
        ref_sel <= 1'b1;
        repeat (10) @(posedge i_clock);
        #1;
        chk(o_synth_lock_flag, 1'b0);
        wait_lock();
        @(posedge i_clock);
        vco_ok <= 1'b0;
        repeat (10) @(posedge i_clock);
        rd(8'h00, image(cur, 1'b0));
        chk(o_chip_resetn, 1'b1);
        @(posedge i_clock);
        vco_ok <= 1'b1;
        wait_lock();
        @(posedge i_clock);
        i_resetn <= 1'b0;
        strap <= 1'b0;
        repeat (20) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (20) @(posedge i_clock);
        #1;
        chk({o_pll_enable, o_chip_resetn, o_synth_lock_flag}, 3'b010);
        // External clock is 40 ns, so 32 cycles hold six or seven edges
        pulses(32);
        chk(16'(cnt >= 6 && cnt <= 7), 16'h0001);
        rd(8'h00, image(16'h3f00, 1'b0));
        complete_run();
    end
    function automatic logic x_bit();
        return o_divs.output_divide_sel;
    endfunction

    initial begin
        repeat (5000) @(posedge i_clock);
        err_count++;
        complete_run();
    end
endmodule

bind pcs_synth_ctrl pcs_synth_ctrl_sva #(.FAST_REF(FAST_REF), .LOCK_CYCLES(LOCK_CYCLES)) u_sva (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data),
    .o_divs(o_divs), .o_pll_enable(o_pll_enable), .o_synth_lock_flag(o_synth_lock_flag),
    .o_sys_clock_en(o_sys_clock_en), .o_chip_resetn(o_chip_resetn));
